// ### common/duia_pkg.sv
// Constants and carrier types of the drive and serial interrupt aggregator.
// Assumes a 32-bit APB master; each register takes one aligned word at four times its index.
package duia_pkg;

  localparam logic [15:0] IDX_SER_FLAGS = 16'hFF78;
  localparam logic [15:0] IDX_SER_MASK = 16'hFF79;
  localparam logic [15:0] IDX_DEC_FLAGS = 16'hFF7A;
  localparam logic [15:0] IDX_DEC_MASK = 16'hFF7B;
  localparam logic [15:0] IDX_ENG_FLAGS = 16'hFF7C;
  localparam logic [15:0] IDX_ENG_MASK = 16'hFF7D;

  localparam logic [31:0] ADDR_SER_FLAGS = {14'h0000, IDX_SER_FLAGS, 2'b00};
  localparam logic [31:0] ADDR_SER_MASK = {14'h0000, IDX_SER_MASK, 2'b00};
  localparam logic [31:0] ADDR_DEC_FLAGS = {14'h0000, IDX_DEC_FLAGS, 2'b00};
  localparam logic [31:0] ADDR_DEC_MASK = {14'h0000, IDX_DEC_MASK, 2'b00};
  localparam logic [31:0] ADDR_ENG_FLAGS = {14'h0000, IDX_ENG_FLAGS, 2'b00};
  localparam logic [31:0] ADDR_ENG_MASK = {14'h0000, IDX_ENG_MASK, 2'b00};

  // Serial group bit positions
  localparam int SER_COM_RISE = 7;
  localparam int SER_SYS_RISE = 6;
  localparam int SER_COM_FALL = 5;
  localparam int SER_SYS_FALL = 4;
  localparam int SER_TX_EMPTY = 3;
  localparam int SER_RX_FULL = 2;
  localparam int SER_OVERRUN = 1;
  localparam int SER_PARITY = 0;

  // Engine group bit positions
  localparam int ENG_HOST_BYTE_ZERO = 7;
  localparam int ENG_DRIVE_RELOAD = 6;
  localparam int ENG_HOST_RELOAD_ZERO = 5;
  localparam int ENG_COPY_END = 4;
  localparam int ENG_SUBCODE_SYNC = 3;
  localparam int ENG_DMA_DONE = 2;
  localparam int ENG_DEC_PEND = 1;
  localparam int ENG_SER_PEND = 0;

  // Decoder group: bits 7..1 latched events, bit 0 engine pending
  localparam int DEC_ENG_PEND = 0;

  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;

  typedef struct packed {
    logic [1:0] sync_s1;
    logic [1:0] sync_s2;
    logic [1:0] sync_prev;
    logic tx_empty_prev;
    logic rx_full_prev;
    logic dma_done_prev;
    logic [7:0] ser_flags;
    logic [7:0] ser_mask;
    logic [7:1] dec_flags;
    logic [7:0] dec_mask;
    logic [7:2] eng_flags;
    logic [7:2] eng_mask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq_n;
  } duia_state_s;

  localparam duia_state_s RST_STATE = '{
    sync_s1: 2'h0, sync_s2: 2'h0, sync_prev: 2'h0,
    tx_empty_prev: 1'b0, rx_full_prev: 1'b0, dma_done_prev: 1'b0,
    ser_flags: RST_FLAGS, ser_mask: RST_MASK,
    dec_flags: RST_FLAGS[7:1], dec_mask: RST_MASK,
    eng_flags: RST_FLAGS[7:2], eng_mask: RST_MASK[7:2],
    pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000, irq_n: 1'b1
  };

endpackage

// ### design/duia_top.sv
// Interrupt aggregator: decoder, engine and serial event groups behind an APB slave.
// Assumes event pulses come from logic on pclk; only the two frame sync pins are asynchronous.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
module duia_top (
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic comsync_pin,
  input logic syssync_pin,
  input logic tx_buf_empty,
  input logic rx_buf_full,
  input logic rx_char_strobe,
  input logic rx_parity_err,
  input logic [7:1] decoder_event_group,
  input logic dma_count_zero,
  input logic dma_run,
  input logic host_byte_count_zero,
  input logic host_reload_count_zero,
  input logic drive_reload,
  input logic copy_end,
  input logic subcode_early_sync,
  output logic aggregate_irq_pin_n
);

  duia_pkg::duia_state_s r;
  duia_pkg::duia_state_s n;

  logic [7:0] ser_set;
  logic [7:0] ser_clr;
  logic [7:1] dec_set;
  logic [7:1] dec_clr;
  logic [7:2] eng_set;
  logic [7:2] eng_clr;
  logic dma_done_now;
  logic dec_pend;
  logic eng_pend;
  logic ser_pend;
  logic access;
  logic wr_fire;
  logic mapped;
  logic [7:0] rd_byte;

  always_comb begin
    n = r;
    ser_set = 8'h00;
    ser_clr = 8'h00;
    dec_set = 7'h00;
    dec_clr = 7'h00;
    eng_set = 6'h00;
    eng_clr = 6'h00;
    dma_done_now = dma_count_zero & dma_run;
    dec_pend = |r.dec_flags;
    eng_pend = |r.eng_flags;
    ser_pend = |r.ser_flags;
    access = psel & penable;
    wr_fire = access & r.pready & pwrite & pstrb[0];
    mapped = (paddr == duia_pkg::ADDR_SER_FLAGS) || (paddr == duia_pkg::ADDR_SER_MASK) ||
             (paddr == duia_pkg::ADDR_DEC_FLAGS) || (paddr == duia_pkg::ADDR_DEC_MASK) ||
             (paddr == duia_pkg::ADDR_ENG_FLAGS) || (paddr == duia_pkg::ADDR_ENG_MASK);
    rd_byte = 8'h00;
    case (paddr)
      duia_pkg::ADDR_SER_FLAGS: begin
        rd_byte = r.ser_flags;
      end
      duia_pkg::ADDR_SER_MASK: begin
        rd_byte = r.ser_mask;
      end
      duia_pkg::ADDR_DEC_FLAGS: begin
        rd_byte = {r.dec_flags, eng_pend & r.dec_mask[duia_pkg::DEC_ENG_PEND]};
      end
      duia_pkg::ADDR_DEC_MASK: begin
        rd_byte = r.dec_mask;
      end
      duia_pkg::ADDR_ENG_FLAGS: begin
        rd_byte = {r.eng_flags, dec_pend, ser_pend};
      end
      duia_pkg::ADDR_ENG_MASK: begin
        rd_byte = {r.eng_mask, 2'b00};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase

    // Event sources
    ser_set[duia_pkg::SER_COM_RISE] = r.sync_s2[0] & ~r.sync_prev[0];
    ser_set[duia_pkg::SER_SYS_RISE] = r.sync_s2[1] & ~r.sync_prev[1];
    ser_set[duia_pkg::SER_COM_FALL] = ~r.sync_s2[0] & r.sync_prev[0];
    ser_set[duia_pkg::SER_SYS_FALL] = ~r.sync_s2[1] & r.sync_prev[1];
    ser_set[duia_pkg::SER_TX_EMPTY] = tx_buf_empty & ~r.tx_empty_prev;
    ser_set[duia_pkg::SER_RX_FULL] = rx_buf_full & ~r.rx_full_prev;
    ser_set[duia_pkg::SER_OVERRUN] = rx_char_strobe & rx_buf_full;
    ser_set[duia_pkg::SER_PARITY] = rx_char_strobe & rx_parity_err;
    dec_set = decoder_event_group;
    eng_set[duia_pkg::ENG_HOST_BYTE_ZERO] = host_byte_count_zero;
    eng_set[duia_pkg::ENG_DRIVE_RELOAD] = drive_reload;
    eng_set[duia_pkg::ENG_HOST_RELOAD_ZERO] = host_reload_count_zero;
    eng_set[duia_pkg::ENG_COPY_END] = copy_end;
    eng_set[duia_pkg::ENG_SUBCODE_SYNC] = subcode_early_sync;
    eng_set[duia_pkg::ENG_DMA_DONE] = dma_done_now & ~r.dma_done_prev;

    if (wr_fire) begin
      case (paddr)
        duia_pkg::ADDR_SER_FLAGS: begin
          ser_clr = pwdata[7:0];
        end
        duia_pkg::ADDR_SER_MASK: begin
          n.ser_mask = pwdata[7:0];
        end
        duia_pkg::ADDR_DEC_FLAGS: begin
          dec_clr = pwdata[7:1];
        end
        duia_pkg::ADDR_DEC_MASK: begin
          n.dec_mask = pwdata[7:0];
        end
        duia_pkg::ADDR_ENG_FLAGS: begin
          eng_clr = pwdata[7:2];
        end
        duia_pkg::ADDR_ENG_MASK: begin
          n.eng_mask = pwdata[7:2];
        end
        default: begin
          n.ser_mask = r.ser_mask;
        end
      endcase
    end

    // Set beats clear so a coincident event survives; the new mask applies at once
    n.ser_flags = ((r.ser_flags & ~ser_clr) | ser_set) & n.ser_mask;
    n.dec_flags = ((r.dec_flags & ~dec_clr) | dec_set) & n.dec_mask[7:1];
    n.eng_flags = ((r.eng_flags & ~eng_clr) | eng_set) & n.eng_mask;

    n.sync_s1 = {syssync_pin, comsync_pin};
    n.sync_s2 = r.sync_s1;
    n.sync_prev = r.sync_s2;
    n.tx_empty_prev = tx_buf_empty;
    n.rx_full_prev = rx_buf_full;
    n.dma_done_prev = dma_done_now;

    // One wait state: pready rises one cycle into the access phase
    if (access & ~r.pready) begin
      n.pready = 1'b1;
      n.pslverr = ~mapped;
      n.prdata = {24'h000000, rd_byte};
    end else begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.prdata = 32'h00000000;
    end

    n.irq_n = ~((|n.dec_flags) | (|n.eng_flags) | (|n.ser_flags));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= duia_pkg::RST_STATE;
    end else if (ce) begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign aggregate_irq_pin_n = r.irq_n;

endmodule

// ### tb/duia_checker.sv
// Checker for the aggregator's APB answer and interrupt pin.
// Assumes it sees only the top module's ports; bound below.
`timescale 1ns/1ns
module duia_checker (
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic aggregate_irq_pin_n
);
  logic wr_done;
  localparam logic [29:0] LO = {14'h0, duia_pkg::IDX_SER_FLAGS};
  localparam logic [29:0] HI = {14'h0, duia_pkg::IDX_ENG_MASK};
  assign wr_done = ce && psel && penable && pready && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready && ce;
  endsequence
  sequence s_ended;
    pready ##1 !pready;
  endsequence
  wait_state_a: assert property (s_access ##1 ce |-> pready)
    else $error("no answer after one wait state");
  pready_pulse_a: assert property (pready |-> s_ended)
    else $error("pready held too long");
  unmapped_err_a: assert property (pready |-> pslverr == (paddr[31:2] < LO || paddr[31:2] > HI))
    else $error("error flag disagrees with map");
  err_data_a: assert property (pready && pslverr |-> prdata == 32'h00000000)
    else $error("data on error answer");
  idle_data_a: assert property (!pready |-> prdata == 32'h00000000)
    else $error("data outside answer");
  upper_zero_a: assert property (prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  irq_hold_a: assert property (!aggregate_irq_pin_n && !wr_done |=> !aggregate_irq_pin_n)
    else $error("pin released without write");
  clear_cause_a: assert property ($rose(aggregate_irq_pin_n) |-> $past(wr_done))
    else $error("pin rose without clear");
endmodule
bind duia_top duia_checker chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .aggregate_irq_pin_n(aggregate_irq_pin_n));

// ### tb/duia_cpu.sv
// Sub-CPU model: an APB master running one transfer per call.
// Assumes one pclk domain; the caller's watchdog ends a hung wait.
`timescale 1ns/1ns
module duia_cpu (
  input logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus must not keep looking valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ### tb/tb.sv
// Bench for the interrupt aggregator: event pulses in, flags read back over APB.
// Assumes the sub-CPU model drives the bus and the checker binds itself.
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [17:0] ev;
    logic [31:0] rd;
    logic [7:0] exp;
    logic [31:0] clr;
  } duia_row_s;
  localparam logic [31:0] SF = duia_pkg::ADDR_SER_FLAGS;
  localparam logic [31:0] DF = duia_pkg::ADDR_DEC_FLAGS;
  localparam logic [31:0] EF = duia_pkg::ADDR_ENG_FLAGS;
  localparam logic [31:0] SM = duia_pkg::ADDR_SER_MASK;
  // Event, register read, expected byte, register cleared
  duia_row_s rows [13] = '{
    '{18'h00008, SF, 8'h08, SF}, '{18'h00006, SF, 8'h06, SF},
    '{18'h00003, SF, 8'h01, SF}, '{18'h00008, EF, 8'h01, SF},
    '{18'h00400, EF, 8'h80, EF}, '{18'h00200, EF, 8'h40, EF},
    '{18'h00100, EF, 8'h20, EF}, '{18'h00080, EF, 8'h10, EF},
    '{18'h00040, EF, 8'h08, EF}, '{18'h00030, EF, 8'h04, EF},
    '{18'h00020, EF, 8'h00, EF}, '{18'h00080, DF, 8'h01, EF},
    '{18'h3F800, DF, 8'hFE, DF}};
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq_n, com, sys, e;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [17:0] ev;
  int n_fail = 0;
  int n_compared = 0;
  duia_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comsync_pin(com), .syssync_pin(sys),
    .tx_buf_empty(ev[3]), .rx_buf_full(ev[2]), .rx_char_strobe(ev[1]), .rx_parity_err(ev[0]),
    .decoder_event_group(ev[17:11]), .dma_count_zero(ev[5]), .dma_run(ev[4]),
    .host_byte_count_zero(ev[10]), .host_reload_count_zero(ev[8]), .drive_reload(ev[9]),
    .copy_end(ev[7]), .subcode_early_sync(ev[6]), .aggregate_irq_pin_n(irq_n));
  duia_cpu cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic pulse(input logic [17:0] p);
    @(posedge pclk);
    ev <= p;
    @(posedge pclk);
    ev <= 18'h0;
  endtask
  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] x);
    cpu.xfer(1'b0, a, 32'h0, rd, e);
    check(name, rd, x);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, rd, e);
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    conclude();
  end
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    ev = 18'h0;
    com = 1'b0;
    sys = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("reset mask", SM, 32'h0);
    check("reset pin", irq_n, 1'b1);
    wr(SM, 32'hFF);
    wr(duia_pkg::ADDR_DEC_MASK, 32'hFF);
    wr(duia_pkg::ADDR_ENG_MASK, 32'hFF);
    foreach (rows[i]) begin
      pulse(rows[i].ev);
      rd_chk("flags", rows[i].rd, {24'h0, rows[i].exp});
      check("pin", irq_n, rows[i].exp == 8'h00);
      wr(rows[i].clr, 32'hFF);
      #1 check("cleared pin", irq_n, 1'b1);
    end
    wr(SM, 32'hF7);
    pulse(18'h00008);
    rd_chk("masked", SF, 32'h0);
    wr(SM, 32'hFF);
    pulse(18'h00008);
    wr(SM, 32'hF7);
    rd_chk("disabled", SF, 32'h0);
    wr(SM, 32'hFF);
    // Sync pins pass a two-flop synchroniser, so allow a few cycles
    com <= 1'b1;
    repeat (5) @(posedge pclk);
    rd_chk("com rise", SF, 32'h80);
    sys <= 1'b1;
    repeat (5) @(posedge pclk);
    rd_chk("sys rise", SF, 32'hC0);
    com <= 1'b0;
    sys <= 1'b0;
    repeat (5) @(posedge pclk);
    rd_chk("falls", SF, 32'hF0);
    wr(SF, 32'h30);
    repeat (20) @(posedge pclk);
    rd_chk("partial clear", SF, 32'hC0);
    wr(SF, 32'hFF);
    // Clock enable low must freeze edge detectors and flags alike
    pulse(18'h00008);
    ce <= 1'b0;
    pulse(18'h00004);
    ce <= 1'b1;
    rd_chk("frozen", SF, 32'h08);
    // Mid-run reset drops every flag and mask and releases the pin
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("reset again pin", irq_n, 1'b1);
    presetn <= 1'b1;
    rd_chk("reset again flags", SF, 32'h0);
    rd_chk("reset again mask", SM, 32'h0);
    rd_chk("unmapped data", 32'h00000100, 32'h0);
    check("unmapped error", e, 1'b1);
    conclude();
  end
endmodule
